//--- hdl/status_pin_pkg.sv
package status_pin_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_A = 8'h1b;
  localparam logic [7:0] IDX_PIN_B = 8'h1c;
  localparam logic [7:0] IDX_REF_IN = 8'h1d;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;
  localparam logic [7:0] IDX_TEST = 8'h23;
  localparam int ADDR_W = 10;

  // reset values
  localparam logic [7:0] RST_PIN_A = 8'h58;
  localparam logic [7:0] RST_PIN_B = 8'h28;
  localparam logic [7:0] RST_REF_IN = 8'h06;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;

  // field layout
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 4;
  localparam int POL_BIT = 3;
  localparam int BYPASS_BIT = 7;
  localparam logic [7:0] PIN_MASK = 8'hf8;
  localparam logic [7:0] REF_IN_MASK = 8'hbf;
  localparam int ANALOG_MSB = 5;
  localparam int TEST_EN_BIT = 0;
  localparam int TEST_A_BIT = 1;
  localparam int TEST_B_BIT = 2;
  localparam logic [7:0] TEST_MASK = 8'h07;

  // indicator codes
  localparam logic [3:0] SEL_LOSS_PRI = 4'h0;
  localparam logic [3:0] SEL_LOSS_SEC = 4'h1;
  localparam logic [3:0] SEL_UNLOCK_1 = 4'h2;
  localparam logic [3:0] SEL_RDIV_1 = 4'h3;
  localparam logic [3:0] SEL_NDIV_1 = 4'h4;
  localparam logic [3:0] SEL_UNLOCK_2 = 4'h5;
  localparam logic [3:0] SEL_RDIV_2 = 4'h6;
  localparam logic [3:0] SEL_NDIV_2 = 4'h7;
  localparam logic [3:0] SEL_CAL_1 = 4'h8;
  localparam logic [3:0] SEL_CAL_2 = 4'h9;
  localparam logic [3:0] SEL_IRQ = 4'ha;
  localparam logic [3:0] SEL_MDIV_1 = 4'hb;
  localparam logic [3:0] SEL_MDIV_2 = 4'hc;
  localparam logic [3:0] SEL_EEPROM = 4'hd;
  localparam logic [3:0] SEL_SWITCH_1 = 4'he;
  localparam logic [3:0] SEL_SWITCH_2 = 4'hf;

  // divider monitor inputs, order of the divClk bus
  localparam int DIV_R1 = 0;
  localparam int DIV_N1 = 1;
  localparam int DIV_R2 = 2;
  localparam int DIV_N2 = 3;
  localparam int DIV_M1 = 4;
  localparam int DIV_M2 = 5;
  localparam int DIV_COUNT = 6;

  // interrupt event bits
  localparam int EV_LOSS_PRI = 0;
  localparam int EV_LOSS_SEC = 1;
  localparam int EV_UNLOCK_1 = 2;
  localparam int EV_UNLOCK_2 = 3;
  localparam int EV_SWITCH_1 = 4;
  localparam int EV_SWITCH_2 = 5;
  localparam int EV_COUNT = 6;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- hdl/monitor_halver.sv
module monitor_halver (
  input wire logic divClk,
  input wire logic rstn,
  output logic half
);
  // runs on the divider output itself so the monitor keeps 50 percent duty
  always_ff @(posedge divClk or negedge rstn) begin
    if (!rstn) begin
      half <= 1'b0;
    end else begin
      half <= ~half;
    end
  end
endmodule

//--- hdl/status_pin_mux.sv
module status_pin_mux (
  input wire logic [3:0] select,
  input wire logic polarity,
  input wire logic testEnable,
  input wire logic testLevel,
  input wire logic [15:0] indicators,
  output logic pin
);
  always_comb begin
    if (testEnable) begin
      pin = testLevel;
    end else begin
      pin = indicators[select] ^ ~polarity;
    end
  end
endmodule

//--- hdl/status_pin_select.sv
// Overview of operation
// - codes 0,1,2,5 give signal and lock loss
// - divider codes route halved R, N, M clocks
// - codes 8,9 show VCO calibration running
// - code 0xA shows combined interrupt flags
// - 0xD EEPROM busy; 0xE,0xF back-to-primary switch
// - per-pin polarity bit, 1 active high
// - pin B has independent identical selector
// - test configuration overrides selector and polarity
// - bypass reports both references valid
// - bypass leaves interrupt and pins untouched
module status_pin_select (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [status_pin_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [status_pin_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic lossPrimary,
  input wire logic lossSecondary,
  input wire logic lockLoss1,
  input wire logic lockLoss2,
  input wire logic calActive1,
  input wire logic calActive2,
  input wire logic eepromActive,
  input wire logic backToPrimary1,
  input wire logic backToPrimary2,
  input wire logic [status_pin_pkg::DIV_COUNT-1:0] divClk,
  output logic statusPinA,
  output logic statusPinB,
  output logic primaryValid,
  output logic secondaryValid,
  output logic [status_pin_pkg::ANALOG_MSB:0] referenceControl,
  output logic combinedInterrupt
);
  import status_pin_pkg::*;

  function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
    byteAddr = {idx, 2'b00};
  endfunction

  logic [7:0] pinAConfig;
  logic [7:0] pinBConfig;
  logic [7:0] refInConfig;
  logic [7:0] testConfig;
  logic [EV_COUNT-1:0] irqStatus;
  logic [EV_COUNT-1:0] irqEnable;
  logic [EV_COUNT-1:0] eventPrev;
  logic [EV_COUNT-1:0] eventNow;
  logic [EV_COUNT-1:0] eventRise;
  logic [EV_COUNT-1:0] clearMask;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic haveAddr;
  logic haveData;
  logic doWrite;
  logic wrHit;
  logic [7:0] next_rdata;
  logic rdHit;
  logic [DIV_COUNT-1:0] halfClk;
  logic [15:0] indicators;

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign awready = !haveAddr;
  assign wready = !haveData;
  assign doWrite = haveAddr && haveData && !bvalid;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      haveAddr <= 1'b0;
      wrAddr <= '0;
    end else if (awvalid && awready) begin
      haveAddr <= 1'b1;
      wrAddr <= awaddr;
    end else if (doWrite) begin
      haveAddr <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      haveData <= 1'b0;
      wrData <= '0;
      wrStrb <= '0;
    end else if (wvalid && wready) begin
      haveData <= 1'b1;
      wrData <= wdata;
      wrStrb <= wstrb;
    end else if (doWrite) begin
      haveData <= 1'b0;
    end
  end

  always_comb begin
    case (wrAddr)
      byteAddr(IDX_PIN_A), byteAddr(IDX_PIN_B), byteAddr(IDX_REF_IN),
      byteAddr(IDX_IRQ_CLEAR), byteAddr(IDX_IRQ_ENABLE), byteAddr(IDX_TEST): wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers; only byte lane 0 carries data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinAConfig <= RST_PIN_A;
      pinBConfig <= RST_PIN_B;
      refInConfig <= RST_REF_IN;
      testConfig <= RST_TEST;
      irqEnable <= RST_IRQ_ENABLE[EV_COUNT-1:0];
    end else if (doWrite && wrStrb[0]) begin
      if (wrAddr == byteAddr(IDX_PIN_A)) begin
        pinAConfig <= wrData[7:0] & PIN_MASK;
      end
      if (wrAddr == byteAddr(IDX_PIN_B)) begin
        pinBConfig <= wrData[7:0] & PIN_MASK;
      end
      if (wrAddr == byteAddr(IDX_REF_IN)) begin
        refInConfig <= wrData[7:0] & REF_IN_MASK;
      end
      if (wrAddr == byteAddr(IDX_TEST)) begin
        testConfig <= wrData[7:0] & TEST_MASK;
      end
      if (wrAddr == byteAddr(IDX_IRQ_ENABLE)) begin
        irqEnable <= wrData[EV_COUNT-1:0];
      end
    end
  end

  assign clearMask = (doWrite && wrStrb[0] && wrAddr == byteAddr(IDX_IRQ_CLEAR)) ?
    wrData[EV_COUNT-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////
  // read channel: one cycle to rvalid
  assign arready = !rvalid;

  always_comb begin
    rdHit = 1'b1;
    case (araddr)
      byteAddr(IDX_PIN_A): next_rdata = pinAConfig;
      byteAddr(IDX_PIN_B): next_rdata = pinBConfig;
      byteAddr(IDX_REF_IN): next_rdata = refInConfig;
      byteAddr(IDX_IRQ_STATUS): next_rdata = {{(8-EV_COUNT){1'b0}}, irqStatus};
      byteAddr(IDX_IRQ_CLEAR): next_rdata = 8'h00;
      byteAddr(IDX_IRQ_ENABLE): next_rdata = {{(8-EV_COUNT){1'b0}}, irqEnable};
      byteAddr(IDX_TEST): next_rdata = testConfig;
      default: begin
        next_rdata = 8'h00;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, next_rdata};
      rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags; raw loss values feed them, bypass never does
  assign eventNow = {backToPrimary2, backToPrimary1, lockLoss2, lockLoss1,
    lossSecondary, lossPrimary};
  assign eventRise = eventNow & ~eventPrev;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      eventPrev <= '0;
      irqStatus <= '0;
    end else begin
      eventPrev <= eventNow;
      // a new event wins over a clear in the same cycle
      irqStatus <= (irqStatus & ~clearMask) | eventRise;
    end
  end

  assign combinedInterrupt = |(irqStatus & irqEnable);

  ////////////////////////////////////////////////////////////////////////
  // reference validity toward the PLL state machines
  assign primaryValid = refInConfig[BYPASS_BIT] || !lossPrimary;
  assign secondaryValid = refInConfig[BYPASS_BIT] || !lossSecondary;
  assign referenceControl = refInConfig[ANALOG_MSB:0];

  ////////////////////////////////////////////////////////////////////////
  // divider monitors; R, N and M outputs only toggle when the divider runs
  genvar gi;
  generate
    for (gi = 0; gi < DIV_COUNT; gi++) begin : g_halve
      monitor_halver u_halver (
        .divClk(divClk[gi]),
        .rstn(rstn),
        .half(halfClk[gi])
      );
    end
  endgenerate

  always_comb begin
    indicators = '0;
    indicators[SEL_LOSS_PRI] = lossPrimary;
    indicators[SEL_LOSS_SEC] = lossSecondary;
    indicators[SEL_UNLOCK_1] = lockLoss1;
    indicators[SEL_UNLOCK_2] = lockLoss2;
    indicators[SEL_RDIV_1] = halfClk[DIV_R1];
    indicators[SEL_NDIV_1] = halfClk[DIV_N1];
    indicators[SEL_RDIV_2] = halfClk[DIV_R2];
    indicators[SEL_NDIV_2] = halfClk[DIV_N2];
    indicators[SEL_MDIV_1] = halfClk[DIV_M1];
    indicators[SEL_MDIV_2] = halfClk[DIV_M2];
    indicators[SEL_CAL_1] = calActive1;
    indicators[SEL_CAL_2] = calActive2;
    indicators[SEL_IRQ] = combinedInterrupt;
    indicators[SEL_EEPROM] = eepromActive;
    indicators[SEL_SWITCH_1] = backToPrimary1;
    indicators[SEL_SWITCH_2] = backToPrimary2;
  end

  ////////////////////////////////////////////////////////////////////////
  // pins stay combinational so monitored clocks pass through unsampled
  status_pin_mux u_pin_a (
    .select(pinAConfig[SEL_MSB:SEL_LSB]),
    .polarity(pinAConfig[POL_BIT]),
    .testEnable(testConfig[TEST_EN_BIT]),
    .testLevel(testConfig[TEST_A_BIT]),
    .indicators(indicators),
    .pin(statusPinA)
  );

  status_pin_mux u_pin_b (
    .select(pinBConfig[SEL_MSB:SEL_LSB]),
    .polarity(pinBConfig[POL_BIT]),
    .testEnable(testConfig[TEST_EN_BIT]),
    .testLevel(testConfig[TEST_B_BIT]),
    .indicators(indicators),
    .pin(statusPinB)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence writeIssued;
    doWrite;
  endsequence

  sequence writeAnswered;
    ##1 bvalid;
  endsequence

  chk_write_response: assert property (@(posedge core_clk) disable iff (!rstn)
    writeIssued |-> writeAnswered)
    else $error("write not answered one cycle later");

  chk_pin_b_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (doWrite && wrStrb[0] && wrAddr == byteAddr(IDX_PIN_B)) |=>
      pinBConfig == ($past(wrData[7:0]) & PIN_MASK) && $stable(pinAConfig))
    else $error("pin b selector not independent");

  chk_loss_route: assert property (@(posedge core_clk) disable iff (!rstn)
    (!testConfig[TEST_EN_BIT] && pinAConfig[SEL_MSB:SEL_LSB] == SEL_LOSS_PRI && pinAConfig[POL_BIT])
      |-> statusPinA == lossPrimary)
    else $error("pin a does not show primary signal loss");

  chk_cal_route: assert property (@(posedge core_clk) disable iff (!rstn)
    (!testConfig[TEST_EN_BIT] && pinBConfig[SEL_MSB:SEL_LSB] == SEL_CAL_2 && pinBConfig[POL_BIT])
      |-> statusPinB == calActive2)
    else $error("pin b does not show calibration");

  chk_pol_invert: assert property (@(posedge core_clk) disable iff (!rstn)
    (!testConfig[TEST_EN_BIT] && pinAConfig[SEL_MSB:SEL_LSB] == SEL_UNLOCK_2 && !pinAConfig[POL_BIT])
      |-> statusPinA == !lockLoss2)
    else $error("active low polarity not applied");

  chk_test_override: assert property (@(posedge core_clk) disable iff (!rstn)
    testConfig[TEST_EN_BIT] |-> statusPinA == testConfig[TEST_A_BIT] && statusPinB == testConfig[TEST_B_BIT])
    else $error("test configuration not overriding pins");

  chk_bypass_valid: assert property (@(posedge core_clk) disable iff (!rstn)
    refInConfig[BYPASS_BIT] |-> primaryValid && secondaryValid)
    else $error("bypass does not force references valid");

  chk_bypass_off: assert property (@(posedge core_clk) disable iff (!rstn)
    !refInConfig[BYPASS_BIT] |-> primaryValid == !lossPrimary && secondaryValid == !lossSecondary)
    else $error("references not following detectors");

  chk_read_answer: assert property (@(posedge core_clk) disable iff (!rstn)
    (arvalid && arready) |=> rvalid)
    else $error("read not answered one cycle later");

  sequence lossRises;
    lossPrimary && !$past(lossPrimary);
  endsequence

  chk_loss_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    lossRises |=> irqStatus[EV_LOSS_PRI] ##1 (irqStatus[EV_LOSS_PRI] || $past(clearMask[EV_LOSS_PRI])))
    else $error("loss event not flagged despite bypass");

  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
    (|(eventRise & irqEnable) && !doWrite) |=> combinedInterrupt && indicators[SEL_IRQ])
    else $error("combined interrupt not raised");

  chk_switch_route: assert property (@(posedge core_clk) disable iff (!rstn)
    (!testConfig[TEST_EN_BIT] && pinAConfig[SEL_MSB:SEL_LSB] == SEL_SWITCH_1 && pinAConfig[POL_BIT])
      |-> statusPinA == backToPrimary1)
    else $error("switch event not routed");
endmodule

//--- dv/status_board_model.sv
module status_board_model (
  input wire logic go,
  input wire logic [2:0] which,
  input wire logic pinA,
  input wire logic pinB,
  output logic [5:0] divClk,
  output int edgesA,
  output int edgesB
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    divClk = '0;
    edgesA = 0;
    edgesB = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one divider at a time, so a wrong route shows as a silent pin
  // clocks stand still between bursts
  always @(posedge go) begin
    edgesA = 0;
    edgesB = 0;
    repeat (8) begin
      #17 divClk[which] = 1'b1;
      #13 divClk[which] = 1'b0;
    end
  end
  always @(posedge pinA) edgesA++;
  always @(posedge pinB) edgesB++;
endmodule

//--- dv/status_pin_signal_select_tb_top.sv
module status_pin_signal_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import status_pin_pkg::*;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("unexpected %0t: got %h want %h", $time, a, e); end end
  logic core_clk = 1'b0, rstn = 1'b1, go = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, r = 32'h512b66b7, rdata;
  logic [8:0] ev = '0;
  logic [2:0] which = '0;
  logic awready, wready, bvalid, arready, rvalid, statusPinA, statusPinB;
  logic primaryValid, secondaryValid, combinedInterrupt;
  logic [1:0] bresp, rresp;
  logic [5:0] divClk, refCtl;
  logic [33:0] expQ[$], want;
  logic [3:0] divCode [6] = '{SEL_RDIV_1, SEL_NDIV_1, SEL_RDIV_2, SEL_NDIV_2, SEL_MDIV_1, SEL_MDIV_2};
  int failures = 0, checks = 0, edgesA, edgesB;
  always #12.5 core_clk = ~core_clk;
  status_pin_select u_status_pin_select (.core_clk(core_clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lossPrimary(ev[0]), .lossSecondary(ev[1]), .lockLoss1(ev[2]),
    .lockLoss2(ev[3]), .calActive1(ev[4]), .calActive2(ev[5]), .eepromActive(ev[6]),
    .backToPrimary1(ev[7]), .backToPrimary2(ev[8]), .divClk(divClk), .statusPinA(statusPinA),
    .statusPinB(statusPinB), .primaryValid(primaryValid), .secondaryValid(secondaryValid),
    .referenceControl(refCtl), .combinedInterrupt(combinedInterrupt));
  status_board_model u_status_board_model (.go(go), .which(which), .pinA(statusPinA),
    .pinB(statusPinB), .divClk(divClk), .edgesA(edgesA), .edgesB(edgesB));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic ind(input logic [3:0] c);
    case (c)
      SEL_LOSS_PRI: return ev[0];
      SEL_LOSS_SEC: return ev[1];
      SEL_UNLOCK_1: return ev[2];
      SEL_UNLOCK_2: return ev[3];
      SEL_CAL_1: return ev[4];
      SEL_CAL_2: return ev[5];
      SEL_EEPROM: return ev[6];
      SEL_SWITCH_1: return ev[7];
      SEL_SWITCH_2: return ev[8];
      default: return 1'b0;
    endcase
  endfunction
  function automatic bit isDiv(input logic [3:0] c);
    return c inside {SEL_RDIV_1, SEL_NDIV_1, SEL_RDIV_2, SEL_NDIV_2, SEL_MDIV_1, SEL_MDIV_2};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rs = RESP_OKAY);
    @(posedge core_clk);
    expQ.push_back({rs, 32'h0});
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rs = RESP_OKAY);
    @(posedge core_clk);
    expQ.push_back({rs, 24'h0, d});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic close_out();
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // oldest note first; one transfer at a time keeps the order
  always @(posedge core_clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      want = expQ.pop_front();
      if (bvalid) `CHK({bresp, 32'h0}, want)
      else `CHK({rresp, rdata}, want)
    end
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
  initial begin
    // a real falling edge, so the halvers on the divider clocks reset too
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd(IDX_PIN_A, RST_PIN_A);
    rd(IDX_PIN_B, RST_PIN_B);
    rd(IDX_REF_IN, RST_REF_IN);
    rd(IDX_TEST, RST_TEST);
    wr(IDX_PIN_A, 8'hff);
    rd(IDX_PIN_A, PIN_MASK);
    wr(8'hff, 8'h00, RESP_SLVERR);
    rd(8'hff, 8'h00, RESP_SLVERR);
    // every code twice, random polarity and indicator levels
    for (int s = 0; s < 32; s++) begin
      wr(IDX_PIN_A, {s[3:0], r[9], 3'h0});
      wr(IDX_PIN_B, {~s[3:0], ~r[9], 3'h0});
      ev <= r[8:0];
      @(negedge core_clk);
      if (!isDiv(s[3:0])) `CHK(statusPinA, ind(s[3:0]) ^ ~r[9])
      if (!isDiv(~s[3:0])) `CHK(statusPinB, ind(~s[3:0]) ^ r[9])
      r = lfsr(r);
    end
    for (int i = 0; i < 6; i++) begin
      wr(IDX_PIN_A, {divCode[i], 4'h8});
      wr(IDX_PIN_B, {divCode[(i + 1) % 6], 4'h0});
      which <= i[2:0];
      go <= 1'b1;
      repeat (12) @(posedge core_clk);
      go <= 1'b0;
      `CHK(edgesA, 4)
      `CHK(edgesB, 0)
    end
    ev <= '0;
    wr(IDX_IRQ_CLEAR, 8'h3f);
    rd(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_IRQ_ENABLE, 8'h01);
    wr(IDX_PIN_A, {SEL_IRQ, 4'h8});
    ev[0] <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(combinedInterrupt, 1'b1)
    `CHK(statusPinA, 1'b1)
    rd(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_ENABLE, 8'h00);
    @(negedge core_clk);
    `CHK(combinedInterrupt, 1'b0)
    `CHK(statusPinA, 1'b0)
    wr(IDX_IRQ_CLEAR, 8'h01);
    rd(IDX_IRQ_STATUS, 8'h00);
    rd(IDX_IRQ_CLEAR, 8'h00);
    // bypass must not hide the real loss from status or pins
    wr(IDX_REF_IN, 8'hff);
    ev[1] <= 1'b1;
    rd(IDX_REF_IN, REF_IN_MASK);
    @(negedge core_clk);
    `CHK(primaryValid, 1'b1)
    `CHK(secondaryValid, 1'b1)
    `CHK(refCtl, 6'h3f)
    rd(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_PIN_A, {SEL_LOSS_SEC, 4'h8});
    @(negedge core_clk);
    `CHK(statusPinA, 1'b1)
    wr(IDX_REF_IN, 8'h00);
    @(negedge core_clk);
    `CHK(primaryValid, 1'b0)
    `CHK(secondaryValid, 1'b0)
    wr(IDX_TEST, 8'h07);
    @(negedge core_clk);
    `CHK({statusPinA, statusPinB}, 2'b11)
    wr(IDX_TEST, 8'h01);
    @(negedge core_clk);
    `CHK({statusPinA, statusPinB}, 2'b00)
    wr(IDX_TEST, 8'h00);
    @(negedge core_clk);
    `CHK(statusPinA, 1'b1)
    @(posedge core_clk);
    close_out();
  end
endmodule
